// ---- pkg/dma_map.vh ----
// Register offsets, field positions, reset values and codes of the five-channel DMA controller.
`ifndef DMA_MAP_VH
`define DMA_MAP_VH

// ==========================================================================
// Register byte offsets
`define DMA_ARM_OFS 12'h000
`define DMA_SWREQ_OFS 12'h004
`define DMA_FLAG_OFS 12'h008
`define DMA_STAT_OFS 12'h00C
`define DMA_CH_BASE 12'h020
`define DMA_CH_END 12'h070
`define DMA_SUB_SRC 2'h0
`define DMA_SUB_DST 2'h1
`define DMA_SUB_CFG 2'h2

// ==========================================================================
// Field positions
`define DMA_ABORT_BIT 7
`define DMA_LEN_LSB 0
`define DMA_VSEL_LSB 13
`define DMA_TRIG_LSB 16
`define DMA_MODE_LSB 21
`define DMA_SIZE_BIT 23
`define DMA_SINC_LSB 24
`define DMA_DINC_LSB 26
`define DMA_MASK_BIT 28
`define DMA_CW8_BIT 29
`define DMA_PRIO_LSB 30

// ==========================================================================
// Reset values
`define DMA_CFG_RST 32'h0000_0000
`define DMA_ADDR_RST 16'h0000

// ==========================================================================
// Codes
`define DMA_VSEL_FIXED 3'h0
`define DMA_VSEL_P1 3'h1
`define DMA_VSEL_P0 3'h2
`define DMA_VSEL_P2 3'h3
`define DMA_VSEL_P3 3'h4
`define DMA_MODE_SINGLE 2'h0
`define DMA_MODE_BLOCK 2'h1
`define DMA_MODE_RSINGLE 2'h2
`define DMA_MODE_RBLOCK 2'h3
`define DMA_INC_ZERO 2'h0
`define DMA_INC_ONE 2'h1
`define DMA_INC_TWO 2'h2
`define DMA_INC_MINUS 2'h3
`define DMA_PRIO_LOW 2'h0
`define DMA_PRIO_NORMAL 2'h1
`define DMA_PRIO_HIGH 2'h2
`define DMA_TRIG_NONE 5'h00
`define DMA_TRIG_PREV 5'h01
`define DMA_TRIG_LAST 5'h1E

`endif

// ---- rtl/five_channel_dma_controller.v ----
// Five-channel DMA controller with APB register slave and one memory master port.
//
// Operation
// - Five independent channels, zero to four.
// - No transfer before the channel is armed.
// - Armed channel starts on its selected trigger.
// - Software request bit starts a transfer only on an armed channel.
// - First item read from source start address.
// - First item written to destination start address.
// - Count transfers, then rearm or disarm, notify.
// - Variable length from first item, word bits 12:0.
// - Fixed count caps variable length.
// - Four variable counts: +1, alone, +2, +3.
// - Seven or eight length bits, bytes only.
// - Single, block, repeated single, repeated block.
// - Each transfer moves a byte or a word.
// - Source and destination stepping set independently.
// - Mask decides whether completion requests an interrupt.
// - Three priority levels order channels and processor.
// - Whole external data space reachable both ways.
// - Single moves one item, block moves all.
// - Pointers loaded on arming, stepped 0,+1,+2,-1.
// - High beats, normal alternates, low yields; round-robin ties.
// - Flag set on completion regardless of mask.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.vh"

module five_channel_dma_controller #(
  parameter NCH = 5,
  parameter AW = 16,
  parameter CW = 13
) (
  input wire pclk,
  input wire presetn,
  input wire en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [30:0] trig_in,
  input wire cpu_req,
  output reg mem_req,
  output reg mem_we,
  output reg mem_word,
  output reg [AW-1:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire mem_ready,
  output reg [NCH-1:0] irq_flag,
  output reg [NCH-1:0] irq_req
);

  // ========================================================================
  // State
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  reg [AW-1:0] src_cfg [0:NCH-1];
  reg [AW-1:0] dst_cfg [0:NCH-1];
  reg [31:0] cfg [0:NCH-1];
  reg [AW-1:0] ptr_s [0:NCH-1];
  reg [AW-1:0] ptr_d [0:NCH-1];
  reg [CW-1:0] done_cnt [0:NCH-1];
  reg [CW-1:0] total [0:NCH-1];
  reg [NCH-1:0] arm;
  reg [NCH-1:0] pend;
  reg [NCH-1:0] first;
  reg [NCH-1:0] done_pulse;
  reg [1:0] st;
  reg [2:0] act;
  reg [2:0] rr;
  reg nrm_defer;

  // ========================================================================
  // APB decode
  wire apb_wr = psel & penable & pwrite & en;
  wire apb_setup = psel & ~penable & en;
  wire in_ch = (paddr >= `DMA_CH_BASE) && (paddr < `DMA_CH_END);
  wire [11:0] ch_off = paddr - `DMA_CH_BASE;
  wire [2:0] sel_ch = ch_off[6:4];
  wire [1:0] sub = ch_off[3:2];
  wire mapped = (paddr == `DMA_ARM_OFS) || (paddr == `DMA_SWREQ_OFS) ||
                (paddr == `DMA_FLAG_OFS) || (paddr == `DMA_STAT_OFS) ||
                (in_ch && (sub != 2'h3) && (paddr[1:0] == 2'h0));
  wire sw_arm = apb_wr && (paddr == `DMA_ARM_OFS);
  wire sw_req = apb_wr && (paddr == `DMA_SWREQ_OFS);
  wire sw_clr = apb_wr && (paddr == `DMA_FLAG_OFS);
  wire abort = sw_arm & pwdata[`DMA_ABORT_BIT];

  // Zero-wait slave; while the block is frozen the access is stretched.
  assign pready = en;

  // ========================================================================
  // Trigger sensing, one per channel
  wire [NCH-1:0] trig_hit;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_trig
      wire [4:0] tsel = cfg[g][`DMA_TRIG_LSB+4:`DMA_TRIG_LSB];
      wire prev_done = done_pulse[(g + NCH - 1) % NCH];
      assign trig_hit[g] = (tsel == `DMA_TRIG_PREV) ? prev_done :
                           ((tsel != `DMA_TRIG_NONE) && (tsel <= `DMA_TRIG_LAST) &&
                            trig_in[tsel]);
    end
  endgenerate

  // ========================================================================
  // Arbitration among channels and against the processor
  reg [2:0] win;
  reg any;
  reg [1:0] best;
  reg [2:0] idx;
  reg [3:0] rr_sum;
  reg [1:0] lvl;
  integer k;
  // Four bits let the round-robin sum pass seven before it is folded back.
  localparam [3:0] NCH_W = NCH[3:0];
  always @* begin
    win = 3'h0;
    any = 1'b0;
    best = 2'h0;
    idx = 3'h0;
    rr_sum = 4'h0;
    lvl = 2'h0;
    for (k = 1; k <= NCH; k = k + 1) begin
      rr_sum = {1'b0, rr} + k[3:0];
      if (rr_sum >= NCH_W) begin
        rr_sum = rr_sum - NCH_W;
      end
      idx = rr_sum[2:0];
      lvl = cfg[idx][`DMA_PRIO_LSB+1:`DMA_PRIO_LSB];
      if (lvl == 2'h3) begin
        lvl = `DMA_PRIO_HIGH;
      end
      // Strictly greater keeps the earliest channel in round-robin order on a tie.
      if (arm[idx] && pend[idx] && (!any || lvl > best)) begin
        any = 1'b1;
        best = lvl;
        win = idx;
      end
    end
  end

  wire go = any && ((best == `DMA_PRIO_HIGH) || !cpu_req ||
                    ((best == `DMA_PRIO_NORMAL) && nrm_defer));

  // ========================================================================
  // Variable length count from the first item
  wire [31:0] acfg = cfg[act];
  wire a_word = acfg[`DMA_SIZE_BIT];
  wire [2:0] a_vsel = acfg[`DMA_VSEL_LSB+2:`DMA_VSEL_LSB];
  wire [CW-1:0] a_len = acfg[`DMA_LEN_LSB+CW-1:`DMA_LEN_LSB];
  wire [1:0] a_mode = acfg[`DMA_MODE_LSB+1:`DMA_MODE_LSB];
  wire [1:0] a_sinc = acfg[`DMA_SINC_LSB+1:`DMA_SINC_LSB];
  wire [1:0] a_dinc = acfg[`DMA_DINC_LSB+1:`DMA_DINC_LSB];
  wire a_var = (a_vsel != `DMA_VSEL_FIXED) && first[act];
  wire [CW-1:0] len_item = a_word ? mem_rdata[12:0] :
                           (acfg[`DMA_CW8_BIT] ? {5'h00, mem_rdata[7:0]} :
                                                {6'h00, mem_rdata[6:0]});
  reg [CW+1:0] var_cnt;
  always @* begin
    case (a_vsel)
      `DMA_VSEL_P1: var_cnt = {2'h0, len_item} + 15'h0001;
      `DMA_VSEL_P2: var_cnt = {2'h0, len_item} + 15'h0002;
      `DMA_VSEL_P3: var_cnt = {2'h0, len_item} + 15'h0003;
      default: var_cnt = {2'h0, len_item};
    endcase
  end
  wire [CW-1:0] var_total = (var_cnt > {2'h0, a_len}) ? a_len : var_cnt[CW-1:0];

  wire [CW-1:0] next_done = done_cnt[act] + 13'h0001;
  wire complete = (next_done >= total[act]);
  wire repeated = (a_mode == `DMA_MODE_RSINGLE) || (a_mode == `DMA_MODE_RBLOCK);
  wire single = (a_mode == `DMA_MODE_SINGLE) || (a_mode == `DMA_MODE_RSINGLE);

  function [AW-1:0] step;
    input [AW-1:0] a;
    input [1:0] inc;
    begin
      case (inc)
        `DMA_INC_ONE: step = a + 16'h0001;
        `DMA_INC_TWO: step = a + 16'h0002;
        `DMA_INC_MINUS: step = a - 16'h0001;
        default: step = a;
      endcase
    end
  endfunction

  // ========================================================================
  // Engine, channel state and register writes
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NCH; i = i + 1) begin
        src_cfg[i] <= `DMA_ADDR_RST;
        dst_cfg[i] <= `DMA_ADDR_RST;
        cfg[i] <= `DMA_CFG_RST;
        ptr_s[i] <= `DMA_ADDR_RST;
        ptr_d[i] <= `DMA_ADDR_RST;
        done_cnt[i] <= 13'h0000;
        total[i] <= 13'h0000;
      end
      arm <= 5'h00;
      pend <= 5'h00;
      first <= 5'h00;
      done_pulse <= 5'h00;
      irq_flag <= 5'h00;
      irq_req <= 5'h00;
      st <= ST_IDLE;
      act <= 3'h0;
      rr <= 3'h0;
      nrm_defer <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (en) begin
      done_pulse <= 5'h00;
      case (st)
        ST_IDLE: begin
          if (any && !go && (best == `DMA_PRIO_NORMAL)) begin
            nrm_defer <= 1'b1;
          end
          if (go) begin
            nrm_defer <= 1'b0;
            act <= win;
            rr <= win;
            st <= ST_READ;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_word <= cfg[win][`DMA_SIZE_BIT];
            mem_addr <= ptr_s[win];
          end
        end
        ST_READ: begin
          if (!arm[act]) begin
            mem_req <= 1'b0;
            st <= ST_IDLE;
          end else if (mem_ready) begin
            if (a_var) begin
              total[act] <= var_total;
            end
            first[act] <= 1'b0;
            mem_wdata <= a_word ? mem_rdata : {8'h00, mem_rdata[7:0]};
            mem_we <= 1'b1;
            mem_addr <= ptr_d[act];
            st <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (!arm[act]) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            st <= ST_IDLE;
          end else if (mem_ready) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            st <= ST_IDLE;
            ptr_s[act] <= step(ptr_s[act], a_sinc);
            ptr_d[act] <= step(ptr_d[act], a_dinc);
            done_cnt[act] <= next_done;
            if (single) begin
              pend[act] <= 1'b0;
            end
            if (complete) begin
              pend[act] <= 1'b0;
              done_pulse[act] <= 1'b1;
              irq_flag[act] <= 1'b1;
              if (repeated) begin
                ptr_s[act] <= src_cfg[act];
                ptr_d[act] <= dst_cfg[act];
                done_cnt[act] <= 13'h0000;
                total[act] <= a_len;
                first[act] <= 1'b1;
              end else begin
                arm[act] <= 1'b0;
              end
            end
          end
        end
        default: begin
          st <= ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase

      // Software writes come after the engine so a write to the arm register wins.
      for (i = 0; i < NCH; i = i + 1) begin
        if (sw_arm) begin
          arm[i] <= pwdata[i] & ~abort;
          if (pwdata[i] && !abort && !arm[i]) begin
            ptr_s[i] <= src_cfg[i];
            ptr_d[i] <= dst_cfg[i];
            done_cnt[i] <= 13'h0000;
            total[i] <= cfg[i][`DMA_LEN_LSB+CW-1:`DMA_LEN_LSB];
            first[i] <= 1'b1;
            pend[i] <= 1'b0;
          end
        end
        // A trigger latches only while armed; it wins over the clear above.
        if ((arm[i] && trig_hit[i]) || (sw_req && pwdata[i])) begin
          pend[i] <= 1'b1;
        end
        if (sw_clr && pwdata[i] && !(st == ST_WRITE && mem_ready && complete &&
                                      act == i[2:0] && arm[i])) begin
          irq_flag[i] <= 1'b0;
        end
        irq_req[i] <= irq_flag[i] & cfg[i][`DMA_MASK_BIT];
      end
      if (apb_wr && in_ch && mapped) begin
        case (sub)
          `DMA_SUB_SRC: src_cfg[sel_ch] <= pwdata[AW-1:0];
          `DMA_SUB_DST: dst_cfg[sel_ch] <= pwdata[AW-1:0];
          default: cfg[sel_ch] <= pwdata;
        endcase
      end

      // Read data and error are set up in the setup phase and shown in the access.
      if (apb_setup) begin
        pslverr <= ~mapped;
        prdata <= 32'h0000_0000;
        if (paddr == `DMA_ARM_OFS) begin
          prdata <= {27'h0, arm};
        end else if (paddr == `DMA_SWREQ_OFS) begin
          prdata <= {27'h0, pend};
        end else if (paddr == `DMA_FLAG_OFS) begin
          prdata <= {27'h0, irq_flag};
        end else if (paddr == `DMA_STAT_OFS) begin
          prdata <= {24'h0, st != ST_IDLE, 2'h0, act, st};
        end else if (mapped) begin
          case (sub)
            `DMA_SUB_SRC: prdata <= {16'h0000, src_cfg[sel_ch]};
            `DMA_SUB_DST: prdata <= {16'h0000, dst_cfg[sel_ch]};
            default: prdata <= cfg[sel_ch];
          endcase
        end
      end
    end
  end

endmodule // five_channel_dma_controller

`default_nettype wire

// ---- testbench/five_channel_dma_controller_monitor.sv ----
// Assertion checker bound to the ports of the five-channel DMA controller.
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.vh"
module five_channel_dma_controller_monitor #(
  parameter NCH = 5,
  parameter AW = 16,
  parameter CW = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [30:0] trig_in,
  input wire logic cpu_req,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_word,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic [NCH-1:0] irq_flag,
  input wire logic [NCH-1:0] irq_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Memory port steps, interrupt flags and APB responses
  sequence rd_done;
    mem_req && !mem_we && mem_ready && en;
  endsequence
  sequence wr_done;
    mem_req && mem_we && mem_ready && en;
  endsequence
  req_hold_a: assert property (mem_req && !(mem_ready && en) |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed early");
  read_write_a: assert property (rd_done |=> mem_req && mem_we)
    else $error("read not followed by write");
  item_size_a: assert property (rd_done |=> mem_word == $past(mem_word))
    else $error("write size differs from read size");
  write_gap_a: assert property (wr_done |=> !mem_req) else $error("no idle cycle after write");
  byte_upper_a: assert property (mem_req && mem_we && !mem_word
    |-> mem_wdata[15:8] == 8'h00) else $error("byte write with upper data set");
  irq_gate_a: assert property ((irq_req & ~$past(irq_flag)) == '0)
    else $error("interrupt request without flag");
  flag_sticky_a: assert property (|($past(irq_flag) & ~irq_flag) |->
    $past(psel && penable && pwrite && en && paddr == `DMA_FLAG_OFS)) else $error("flag lost");
  unmapped_err_a: assert property (psel && !penable && en && paddr >= `DMA_CH_END
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && !penable && en && paddr[11:4] == 8'h00
    && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped access refused");
  pready_en_a: assert property (pready == en) else $error("pready differs from enable");
endmodule // five_channel_dma_controller_monitor
bind five_channel_dma_controller five_channel_dma_controller_monitor #(.NCH(NCH), .AW(AW),
  .CW(CW)) u_mon (.pclk(pclk), .presetn(presetn), .en(en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trig_in(trig_in), .cpu_req(cpu_req), .mem_req(mem_req), .mem_we(mem_we),
  .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .mem_ready(mem_ready), .irq_flag(irq_flag), .irq_req(irq_req));
`default_nettype wire

// ---- testbench/dma_mem_model.sv ----
// Behavioural data memory answering the DMA master port after a set latency.
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic word,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] lat,
  output logic ready,
  output logic [15:0] rdata
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt;
  // Read data toggles outside the ready cycle so stale data never passes for an answer.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      cnt <= 2'h0;
      rdata <= 16'hA5A5;
    end else if (req && !ready && cnt == lat) begin
      ready <= 1'b1;
      cnt <= 2'h0;
      rdata <= {word ? mem[addr[7:0] + 8'h01] : 8'h00, mem[addr[7:0]]};
      if (we) begin
        mem[addr[7:0]] <= wdata[7:0];
        if (word) begin
          mem[addr[7:0] + 8'h01] <= wdata[15:8];
        end
      end
    end else begin
      ready <= 1'b0;
      cnt <= (req && !ready) ? cnt + 2'h1 : 2'h0;
      rdata <= ~rdata;
    end
  end
endmodule // dma_mem_model
`default_nettype wire

// ---- testbench/five_channel_dma_controller_tb.sv ----
// Self-checking testbench of the five-channel DMA controller.
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.vh"
module five_channel_dma_controller_tb;
  logic pclk, presetn, en, psel, penable, pwrite, cpu_req, pready, pslverr, rerr;
  logic mem_req, mem_we, mem_word, mem_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [30:0] trig_in;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [4:0] irq_flag, irq_req;
  logic [1:0] lat;
  int n_mismatch, num_checks;
  int vl[6] = '{`DMA_VSEL_P1, `DMA_VSEL_P0, `DMA_VSEL_P2, `DMA_VSEL_P3, `DMA_VSEL_P3, `DMA_VSEL_P1};
  int w8[6] = '{0, 0, 0, 0, 0, 1};
  int cap[6] = '{15, 15, 15, 15, 3, 6};
  int nx[6] = '{3, 2, 4, 5, 3, 6};
  five_channel_dma_controller dut (.pclk(pclk), .presetn(presetn), .en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .cpu_req(cpu_req),
    .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .irq_flag(irq_flag), .irq_req(irq_req));
  dma_mem_model mm (.clk(pclk), .rst_n(presetn), .req(mem_req), .we(mem_we), .word(mem_word),
    .addr(mem_addr), .wdata(mem_wdata), .lat(lat), .ready(mem_ready), .rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================================
  // Tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    n_mismatch++;
    $display("ERROR %0t wait ran out", $time);
    summarize();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) hang();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_flag(input int ch);
    int k;
    k = 0;
    while (irq_flag[ch] !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (irq_flag[ch] !== 1'b1) hang();
  endtask
  task automatic pulse(input int i);
    trig_in[i] <= 1'b1;
    @(posedge pclk);
    trig_in <= 31'h0;
  endtask
  function automatic logic [31:0] cfg(input int n, vl, tr, md, wd, si, di, mk, w8, pr);
    cfg = (n << `DMA_LEN_LSB) | (vl << `DMA_VSEL_LSB) | (tr << `DMA_TRIG_LSB);
    cfg = cfg | (md << `DMA_MODE_LSB) | (wd << `DMA_SIZE_BIT) | (si << `DMA_SINC_LSB);
    cfg = cfg | (di << `DMA_DINC_LSB) | (mk << `DMA_MASK_BIT) | (w8 << `DMA_CW8_BIT);
    cfg = cfg | (pr << `DMA_PRIO_LSB);
  endfunction
  function automatic logic [7:0] pat(input int a);
    pat = 8'(a) ^ 8'h5A;
  endfunction
  task automatic setup(input int ch, input logic [15:0] s, d, input logic [31:0] c);
    logic [11:0] b;
    b = `DMA_CH_BASE + 12'(ch * 16);
    apb(1'b1, b, {16'h0, s});
    apb(1'b1, b + 12'h004, {16'h0, d});
    apb(1'b1, b + 12'h008, c);
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    int d;
    presetn = 1'b0;
    en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig_in = 31'h0;
    cpu_req = 1'b0;
    lat = 2'h0;
    for (int i = 0; i < 256; i++) mm.mem[i] = pat(i);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `DMA_CH_BASE + 12'h008, 32'h0);
    check(rdat, `DMA_CFG_RST);
    apb(1'b0, 12'hFFC, 32'h0);
    check({rerr, rdat[30:0]}, 32'h80000000);
    en <= 1'b0;
    repeat (2) @(posedge pclk);
    check(pready, 1'b0);
    en <= 1'b1;
    // Destination areas below are plain writable memory.
    setup(0, 16'h0010, 16'h0040, cfg(4, 0, 5, `DMA_MODE_BLOCK, 0, 1, 1, 1, 0, `DMA_PRIO_HIGH));
    pulse(5);
    repeat (20) @(posedge pclk);
    check(mm.mem[8'h40], pat(8'h40));
    cpu_req <= 1'b1;
    apb(1'b1, `DMA_ARM_OFS, 32'h1);
    apb(1'b1, `DMA_SWREQ_OFS, 32'h1);
    wait_flag(0);
    cpu_req <= 1'b0;
    for (int i = 0; i < 5; i++) check(mm.mem[8'h40 + i], pat(i < 4 ? 8'h10 + i : 8'h44));
    apb(1'b0, `DMA_ARM_OFS, 32'h0);
    check({irq_req[0], rdat[0]}, 2'b10);
    apb(1'b1, `DMA_FLAG_OFS, 32'h1);
    apb(1'b0, `DMA_FLAG_OFS, 32'h0);
    check(rdat[0], 1'b0);
    lat <= 2'h2;
    setup(1, 16'h0080, 16'h00C0, cfg(2, 0, 5, `DMA_MODE_SINGLE, 1, 2, 0, 0, 0, 1));
    apb(1'b1, `DMA_ARM_OFS, 32'h2);
    pulse(5);
    repeat (40) @(posedge pclk);
    check({irq_flag[1], mm.mem[8'hC1], mm.mem[8'hC0]}, {1'b0, pat(8'h81), pat(8'h80)});
    pulse(5);
    wait_flag(1);
    check({irq_req[1], mm.mem[8'hC1], mm.mem[8'hC0]}, {1'b0, pat(8'h83), pat(8'h82)});
    check(mm.mem[8'hC2], pat(8'hC2));
    lat <= 2'h1;
    mm.mem[8'h60] = 8'h82;
    for (int k = 0; k < 6; k++) begin
      d = 8'hC8 + 8 * k;
      setup(2, 16'h0060, 16'(d), cfg(cap[k], vl[k], 0, `DMA_MODE_BLOCK, 0, 1, 1, 1, w8[k], 1));
      apb(1'b1, `DMA_ARM_OFS, 32'h4);
      apb(1'b1, `DMA_SWREQ_OFS, 32'h4);
      wait_flag(2);
      check(mm.mem[8'(d + nx[k] - 1)], mm.mem[8'(8'h60 + nx[k] - 1)]);
      check(mm.mem[8'(d + nx[k])], pat(d + nx[k]));
      apb(1'b1, `DMA_FLAG_OFS, 32'h4);
    end
    setup(4, 16'h0010, 16'h0048, cfg(2, 0, 0, `DMA_MODE_RBLOCK, 0, 1, 1, 1, 0, 0));
    cpu_req <= 1'b1;
    apb(1'b1, `DMA_ARM_OFS, 32'h10);
    apb(1'b1, `DMA_SWREQ_OFS, 32'h10);
    repeat (30) @(posedge pclk);
    check({irq_flag[4], mm.mem[8'h48]}, {1'b0, pat(8'h48)});
    cpu_req <= 1'b0;
    wait_flag(4);
    apb(1'b0, `DMA_ARM_OFS, 32'h0);
    check({rdat[4], mm.mem[8'h49]}, {1'b1, pat(8'h11)});
    // Normal priority must get through a busy processor; repeated single rearms.
    setup(3, 16'h0030, 16'h0058, cfg(2, 0, 0, `DMA_MODE_RSINGLE, 0, `DMA_INC_MINUS, 1, 0, 0,
      `DMA_PRIO_NORMAL));
    cpu_req <= 1'b1;
    apb(1'b1, `DMA_ARM_OFS, 32'h8);
    apb(1'b1, `DMA_SWREQ_OFS, 32'h8);
    repeat (20) @(posedge pclk);
    check({irq_flag[3], mm.mem[8'h58]}, {1'b0, pat(8'h30)});
    apb(1'b1, `DMA_SWREQ_OFS, 32'h8);
    wait_flag(3);
    cpu_req <= 1'b0;
    check(mm.mem[8'h59], pat(8'h2F));
    apb(1'b0, `DMA_ARM_OFS, 32'h0);
    check(rdat[3], 1'b1);
    apb(1'b0, `DMA_STAT_OFS, 32'h0);
    check(rdat, 32'h0000_000C);
    apb(1'b1, `DMA_ARM_OFS, 32'h80);
    apb(1'b0, `DMA_ARM_OFS, 32'h0);
    check(rdat[4:0], 5'h00);
    summarize();
  end
endmodule // five_channel_dma_controller_tb
`default_nettype wire
